// ===== core/asrc_defines.svh
// Timing constants for the asynchronous static memory controller
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
`define ASRC_CLK_PERIOD_NS 40
`define ASRC_CYCLE_MIN_NS 12
`define ASRC_ADDR_TO_WEND_NS 8
`define ASRC_WPULSE_MIN_NS 8
`define ASRC_WE_TO_HIZ_NS 5
`define ASRC_DATA_SETUP_NS 6
`define ASRC_ACCESS_NS 12
`define ASRC_DIV_UP(t) (((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_WPULSE_CYC \
  `ASRC_DIV_UP(`ASRC_WE_TO_HIZ_NS + `ASRC_DATA_SETUP_NS)
`define ASRC_ACCESS_CYC `ASRC_DIV_UP(`ASRC_ACCESS_NS)
`define ASRC_CYCLE_CYC `ASRC_DIV_UP(`ASRC_CYCLE_MIN_NS)
`endif

// ===== core/asrc_pkg.sv
// Types for the asynchronous static memory controller
package asrc_pkg;
  typedef enum logic [2:0] {
    IDLE, RD_WAIT, RD_DONE, WR_SETUP, WR_PULSE, WR_HOLD
  } asrc_state_type;
endpackage : asrc_pkg

// ===== core/asrc_host.sv
// Host controller driving an asynchronous 128K x 8 static memory
//
// Overview of operation
// (RL1) Memory has 131072 bytes, 17-bit address, 8-bit two-way data.
// (RL2) Memory is static and clockless; host needs no refresh.
// (RL3) Read: write strobe high, select and output enable low.
// (RL4) Memory stores data while select and write strobe are both low.
// (RL5) Select high floats memory data pins and puts it in standby.
// (RL6) Each read or write cycle lasts at least 12 ns.
// (RL7) Read data valid 12 ns after stable address.
// (RL8) Read data valid 6 ns after output enable falls.
// (RL9) Read data valid 12 ns after select falls.
// (RL10) Memory outputs stay off at least 3 ns after select falls.
// (RL11) Outputs float within 6 ns after select rises.
// (RL12) Outputs float within 5 ns after output enable rises.
// (RL13) Old read data holds at least 4 ns after address change.
// (RL14) Address and select valid at least 8 ns before write end.
// (RL15) Write pulse covers strobe-to-float plus data setup if enable low.
// (RL16) Write data valid 6 ns before write end, held afterwards.
// (RL17) Memory outputs float within 5 ns of write strobe falling.
// (RL18) Memory outputs stay off at least 3 ns after write end.
// (RL19) Select falling at or after strobe keeps outputs off.
// (RL20) Host never drives data while memory drives it.
// (RL21) Address valid no later than select falls.
// (RL22) Standby within 12 ns of deselect; instant wake-up.
// (RL23) Address held steady while select and write strobe are low.
// (RL24) A read returns the byte last written there.
`timescale 1ns/1ns
`include "asrc_defines.svh"
module asrc_host #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8,
  parameter int WPULSE_CYC = `ASRC_WPULSE_CYC,
  parameter int ACCESS_CYC = `ASRC_ACCESS_CYC,
  parameter int CYCLE_CYC = `ASRC_CYCLE_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspRdata,
  output logic [ADDR_W-1:0] memAddr,
  output logic memSel_n,
  output logic memOen_n,
  output logic memWe_n,
  input wire logic [DATA_W-1:0] memDataIn,
  output logic [DATA_W-1:0] memDataOut,
  output logic memDataOe
);
  // Counts below one would drop a phase, so each is at least one
  localparam logic [7:0] WP = 8'(WPULSE_CYC < 1 ? 1 : WPULSE_CYC);
  localparam logic [7:0] AC = 8'(ACCESS_CYC < 1 ? 1 : ACCESS_CYC);
  localparam logic [7:0] CY = 8'(CYCLE_CYC < 1 ? 1 : CYCLE_CYC);

  asrc_pkg::asrc_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] sync1_q, sync2_q;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // Pin registers and their next values
  logic sel_n_q, sel_n_d;
  logic oen_n_q, oen_n_d;
  logic we_n_q, we_n_d;
  logic dOe_q, dOe_d;
  logic ready_q, ready_d;
  logic rspV_q, rspV_d;

  // Counter value one marks the last cycle of a wait
  wire cntDone = (cnt_q == 8'h01);
  wire accept = ready_q && reqValid;

  // Next-state decodes feed the pin and handshake logic
  wire goRdWait = (state_d == asrc_pkg::RD_WAIT);
  wire goRdDone = (state_d == asrc_pkg::RD_DONE);
  wire goWrSetup = (state_d == asrc_pkg::WR_SETUP);
  wire goWrPulse = (state_d == asrc_pkg::WR_PULSE);
  wire goWrHold = (state_d == asrc_pkg::WR_HOLD);
  wire goIdle = (state_d == asrc_pkg::IDLE);
  wire opEnds = (state_q == asrc_pkg::RD_DONE) ||
    (state_q == asrc_pkg::WR_HOLD);

  // Read data pin input synchronised before use
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= memDataIn;
      sync2_q <= sync1_q;
    end
  end

  // Next state and wait counter
  always_comb begin
    state_d = state_q;
    cnt_d = cntDone ? cnt_q : cnt_q - 8'h01;
    unique case (state_q)
      asrc_pkg::IDLE: begin
        if (accept) begin
          // Address loads no later than select falls (RL21)
          state_d = reqWrite ? asrc_pkg::WR_SETUP : asrc_pkg::RD_WAIT;
          // Two extra edges cover the input synchroniser (RL7)
          cnt_d = reqWrite ? 8'h01 : AC + 8'h02;
        end
      end
      asrc_pkg::RD_WAIT: begin
        if (cntDone) state_d = asrc_pkg::RD_DONE;
      end
      asrc_pkg::RD_DONE: begin
        state_d = asrc_pkg::IDLE;
      end
      asrc_pkg::WR_SETUP: begin
        state_d = asrc_pkg::WR_PULSE;
        // Pulse lasts the longer of write pulse and cycle time (RL15)
        cnt_d = (WP > CY) ? WP : CY; // RL6
      end
      asrc_pkg::WR_PULSE: if (cntDone) begin
        state_d = asrc_pkg::WR_HOLD;
      end
      asrc_pkg::WR_HOLD: begin
        // Write has ended; data stays driven through this cycle
        state_d = asrc_pkg::IDLE;
      end
    endcase
  end

  // Sequencer state and its wait counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= asrc_pkg::IDLE;
      cnt_q <= 8'h01;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Select low only to read or inside the write pulse
  assign sel_n_d = !(goRdWait || goWrPulse); // RL3 RL14
  // Enable low only to read, high through every write
  assign oen_n_d = !goRdWait; // RL3 RL15
  // Strobe falls a cycle before select and rises with it
  assign we_n_d = !(goWrSetup || goWrPulse); // RL15 RL19
  // Data driven from strobe fall to one cycle past write end
  assign dOe_d = goWrSetup || goWrPulse || goWrHold; // RL16 RL20

  // Strobes reset inactive, leaving the memory in standby
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_n_q <= 1'b1;
      oen_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dOe_q <= 1'b0;
    end else begin
      sel_n_q <= sel_n_d;
      oen_n_q <= oen_n_d;
      we_n_q <= we_n_d;
      dOe_q <= dOe_d;
    end
  end

  // Request fields load only in idle, never inside a write
  assign addr_d = accept ? reqAddr : addr_q; // RL21 RL23
  assign wdata_d = accept ? reqWdata : wdata_q; // RL16
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // Read byte comes from the synchronised pins on leaving the wait
  assign rdata_d = goRdDone ? sync2_q : rdata_q; // RL3
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Ready only in idle, and low on the edge that takes a request
  assign ready_d = goIdle && !accept;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // One-cycle answer pulse as either kind of transfer ends
  assign rspV_d = opEnds;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspV_q <= 1'b0;
    end else begin
      rspV_q <= rspV_d;
    end
  end

  // Read response carries last captured byte (RL24)
  assign rspRdata = rdata_q;

  // Every other output comes straight from its register
  assign rspValid = rspV_q;
  assign reqReady = ready_q;
  assign memAddr = addr_q;
  assign memSel_n = sel_n_q;
  assign memOen_n = oen_n_q;
  assign memWe_n = we_n_q;
  assign memDataOut = wdata_q;
  assign memDataOe = dOe_q;
endmodule : asrc_host

// ===== tb/asrc_properties.sv
// Port-level checks of the static memory host controller
`timescale 1ns/1ns
module asrc_properties #(parameter int ADDR_W = 17, parameter int DATA_W = 8) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memSel_n,
  input wire logic memOen_n,
  input wire logic memWe_n,
  input wire logic [DATA_W-1:0] memDataOut,
  input wire logic memDataOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  no_clash_a: assert property (memDataOe |-> memOen_n)
    else $error("host drives data while memory output is on");
  read_strobe_a: assert property (!memOen_n |-> memWe_n && !memSel_n)
    else $error("read without strobe high and select low");
  write_oen_a: assert property (!memWe_n |-> memOen_n)
    else $error("output enable low during write");
  addr_hold_a: assert property (!memSel_n && !$fell(memSel_n) |->
    $stable(memAddr)) else $error("address moved while selected");
  wdata_hold_a: assert property (!memSel_n && !memWe_n |->
    memDataOe && $stable(memDataOut) ##1 memDataOe)
    else $error("write data not held around write end");
  write_setup_a: assert property (!memSel_n && !memWe_n |->
    !$past(memWe_n)) else $error("strobe not set up before select");
  write_select_a: assert property ($rose(memWe_n) |->
    !$past(memSel_n)) else $error("select not low before write end");
  read_hold_a: assert property ($fell(memOen_n) |-> !memSel_n [*3])
    else $error("read cycle too short");
  rd_latency_a: assert property (reqValid && reqReady && !reqWrite |->
    ##5 rspValid) else $error("read answer late or missing");
  wr_latency_a: assert property (reqValid && reqReady && reqWrite |->
    ##4 rspValid) else $error("write answer late or missing");
  cover property (reqValid && reqReady && reqWrite);
  cover property (reqValid && reqReady && !reqWrite);
  cover property ($rose(memWe_n) && memDataOe);
endmodule : asrc_properties
bind asrc_host asrc_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  i_asrc_properties (.core_clk(core_clk), .arst_n(arst_n),
  .reqValid(reqValid), .reqWrite(reqWrite), .reqReady(reqReady),
  .rspValid(rspValid), .memAddr(memAddr), .memSel_n(memSel_n),
  .memOen_n(memOen_n), .memWe_n(memWe_n), .memDataOut(memDataOut),
  .memDataOe(memDataOe));

// ===== tb/asrc_mem_model.sv
// Behavioural static memory on the far side of the controller
`timescale 1ns/1ns
module asrc_mem_model #(parameter int ACC_NS = 12, parameter int OE_NS = 6) (
  input wire logic [16:0] memAddr,
  input wire logic memSel_n,
  input wire logic memOen_n,
  input wire logic memWe_n,
  input wire logic [7:0] memDataOut,
  input wire logic memDataOe,
  output logic [7:0] memDataIn
);
  logic [7:0] cells [0:131071];
  logic [7:0] rdVal;
  logic devOnDly;
  // Select high, enable high or strobe low turns the outputs off
  wire devOn = !memSel_n && !memOen_n && memWe_n;
  // Outputs turn on late and off at once, inside every window
  assign #(OE_NS, 0) devOnDly = devOn;
  // Inertial delay keeps the old byte well past an address change
  assign #ACC_NS rdVal = cells[memAddr];
  // Released bus shows inverted data so stale values never pass
  assign memDataIn = memDataOe ? memDataOut : devOnDly ? rdVal : ~rdVal;
  always @* if (!memSel_n && !memWe_n) cells[memAddr] = memDataIn;
endmodule : asrc_mem_model

// ===== tb/test_asrc_host.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_asrc_host;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [16:0] reqAddr = 17'h00000;
  logic [7:0] reqWdata = 8'h00;
  logic reqReady, rspValid, memSel_n, memOen_n, memWe_n, memDataOe;
  logic [7:0] rspRdata, memDataIn, memDataOut, rd;
  logic [16:0] memAddr;
  int n_errors = 0;
  int samples_checked = 0;
  always #20 core_clk = ~core_clk;
  asrc_host i_asrc_host (.core_clk(core_clk), .arst_n(arst_n),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .memAddr(memAddr), .memSel_n(memSel_n),
    .memOen_n(memOen_n), .memWe_n(memWe_n), .memDataIn(memDataIn),
    .memDataOut(memDataOut), .memDataOe(memDataOe));
  asrc_mem_model i_asrc_mem_model (.memAddr(memAddr), .memSel_n(memSel_n),
    .memOen_n(memOen_n), .memWe_n(memWe_n), .memDataOut(memDataOut),
    .memDataOe(memDataOe), .memDataIn(memDataIn));
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic xfer(input logic wr, input logic [16:0] a,
    input logic [7:0] d);
    int i;
    i = 0;
    while (reqReady !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1 i++;
    end
    `CHK("reqReady", 1'b1, reqReady)
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    @(posedge core_clk);
    #1 reqValid = 1'b0;
    `CHK("memAddr", a, memAddr)
    if (wr) `CHK("memDataOut", d, memDataOut)
    i = 0;
    while (rspValid !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1 i++;
    end
    `CHK("rspValid", 1'b1, rspValid)
    rd = rspRdata;
  endtask : xfer
  task automatic test_corners();
    xfer(1'b1, 17'h00000, 8'hA5);
    xfer(1'b1, 17'h1FFFF, 8'h3C);
    xfer(1'b0, 17'h00000, 8'h00);
    `CHK("rspRdata", 8'hA5, rd)
    xfer(1'b0, 17'h1FFFF, 8'h00);
    `CHK("rspRdata", 8'h3C, rd)
    $display("test_corners done");
  endtask : test_corners
  task automatic test_overwrite();
    xfer(1'b1, 17'h00055, 8'h0F);
    xfer(1'b1, 17'h00055, 8'hF0);
    xfer(1'b0, 17'h00055, 8'h00);
    `CHK("rspRdata", 8'hF0, rd)
    xfer(1'b0, 17'h00055, 8'h00);
    `CHK("rspRdata", 8'hF0, rd)
    $display("test_overwrite done");
  endtask : test_overwrite
  task automatic test_reset();
    xfer(1'b1, 17'h00AAA, 8'h5A);
    @(posedge core_clk);
    #1 arst_n = 1'b0;
    #1 `CHK("memSel_n", 1'b1, memSel_n)
    `CHK("memDataOe", 1'b0, memDataOe)
    `CHK("reqReady", 1'b0, reqReady)
    @(posedge core_clk);
    #1 arst_n = 1'b1;
    xfer(1'b0, 17'h00AAA, 8'h00);
    `CHK("rspRdata", 8'h5A, rd)
    $display("test_reset done");
  endtask : test_reset
  initial begin
    repeat (16) @(posedge core_clk);
    `CHK("memSel_n", 1'b1, memSel_n)
    `CHK("memDataOe", 1'b0, memDataOe)
    #1 arst_n = 1'b1;
    test_corners();
    test_overwrite();
    test_reset();
    test_done();
  end
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule : test_asrc_host
